// *** verilog/port_config_and_data_regs.sv ***
// Purpose: port b and c configuration registers and port a, b, c data registers
// Assumes: core issues one-cycle read and write strobes per register space
// Notes:   pin levels pass a two-stage synchroniser before any read
// Operation
// - port b pull-up bit set enables that pin's pull-up
// - port b option bit feeds its pin's mode selection
// - port b direction bit zero is input, one is output
// - port c pull-up bits 5..0 enable pull-ups; bits 7,6 unused
// - port c option bits 5..0 feed mode selection; upper bits unused
// - port c direction bits 5..0 select input or output
// - port b function bit routes pin to analog channel; bit 0 also reference
// - port c function bits route to timer reset, tx, spi ss/miso/mosi/sck
// - input registers at 00h..02h return digital input levels
// - input registers are read-only with no defined reset value
// - output register writes drive pins configured as outputs
// - output registers are write-only and clear on reset
// - configuration registers 1ch..23h are read/write and reset to zero
// - port c data registers are meaningless in the smallest packages
// - pull-up/option/direction decode into eight pin modes
// - pull-up and option reach pins only when direction is written
// - port b and c input reads return last written value for output pins
module port_config_and_data_regs (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // input register space read
  input  wire logic       in_rd,
  input  wire logic [7:0] in_addr,
  // output register space write
  input  wire logic       out_wr,
  input  wire logic [7:0] out_addr,
  input  wire logic [7:0] out_wdata,
  // configuration register space
  input  wire logic       cfg_rd,
  input  wire logic       cfg_wr,
  input  wire logic [7:0] cfg_addr,
  input  wire logic [7:0] cfg_wdata,
  // read data to core
  output logic      [7:0] rdata_r,
  output logic            rvalid_r,
  // pins: levels in
  input  wire logic [7:0] porta_pin_in,
  input  wire logic [7:0] portb_pin_in,
  input  wire logic [5:0] portc_pin_in,
  // port a drive (configuration of port a lives elsewhere)
  output logic      [7:0] porta_drive_bits_r,
  // port b pad controls
  output logic      [7:0] portb_pad_out_r,
  output logic      [7:0] portb_pad_oe_r,
  output logic      [7:0] portb_pad_pullup_r,
  output logic      [7:0] portb_pad_weak_r,
  output logic      [7:0] portb_pad_irq_en_r,
  output logic      [7:0] analog_channel_in_r,
  // port c pad controls
  output logic      [5:0] portc_pad_out_r,
  output logic      [5:0] portc_pad_oe_r,
  output logic      [5:0] portc_pad_pullup_r,
  output logic      [5:0] portc_pad_weak_r,
  output logic      [5:0] portc_pad_irq_en_r,
  // port c peripheral hookup
  input  wire logic [5:0] portc_alt_out,
  input  wire logic [5:0] portc_alt_oe,
  output logic      [5:0] portc_function_bit_r,
  output logic            timer_reset_in_r
);
  // programmed (shadow) and latched configuration
  logic [7:0] b_pull_r, b_pull_nxt, b_opt_r, b_opt_nxt, b_dir_r, b_dir_nxt;
  logic [7:0] b_func_r, b_func_nxt;
  logic [7:0] c_pull_r, c_pull_nxt, c_opt_r, c_opt_nxt, c_dir_r, c_dir_nxt;
  logic [7:0] c_func_r, c_func_nxt;
  logic [7:0] b_pull_act_r, b_pull_act_nxt, b_opt_act_r, b_opt_act_nxt;
  logic [7:0] c_pull_act_r, c_pull_act_nxt, c_opt_act_r, c_opt_act_nxt;
  logic [7:0] a_drv_r, a_drv_nxt, b_drv_r, b_drv_nxt, c_drv_r, c_drv_nxt;
  logic [7:0] rdata_nxt;
  logic       rvalid_nxt;
  // synchronisers
  logic [7:0] a_meta_r, a_sync_r, b_meta_r, b_sync_r;
  logic [5:0] c_meta_r, c_sync_r;

  // pin levels cross in through two flops
  always_ff @(posedge sys_clk) begin
    a_meta_r <= porta_pin_in;
    a_sync_r <= a_meta_r;
    b_meta_r <= portb_pin_in;
    b_sync_r <= b_meta_r;
    c_meta_r <= portc_pin_in;
    c_sync_r <= c_meta_r;
  end

  // configuration and output register writes
  always_comb begin
    b_pull_nxt     = b_pull_r;
    b_opt_nxt      = b_opt_r;
    b_dir_nxt      = b_dir_r;
    b_func_nxt     = b_func_r;
    c_pull_nxt     = c_pull_r;
    c_opt_nxt      = c_opt_r;
    c_dir_nxt      = c_dir_r;
    c_func_nxt     = c_func_r;
    b_pull_act_nxt = b_pull_act_r;
    b_opt_act_nxt  = b_opt_act_r;
    c_pull_act_nxt = c_pull_act_r;
    c_opt_act_nxt  = c_opt_act_r;
    a_drv_nxt      = a_drv_r;
    b_drv_nxt      = b_drv_r;
    c_drv_nxt      = c_drv_r;
    if (cfg_wr) begin
      if (cfg_addr == port_pkg::ADDR_B_PULLUP) begin
        b_pull_nxt = cfg_wdata;
      end else if (cfg_addr == port_pkg::ADDR_B_OPTION) begin
        b_opt_nxt = cfg_wdata;
      end else if (cfg_addr == port_pkg::ADDR_B_DIRECTION) begin
        b_dir_nxt      = cfg_wdata;
        b_pull_act_nxt = b_pull_r; // latch companions on direction write
        b_opt_act_nxt  = b_opt_r;
      end else if (cfg_addr == port_pkg::ADDR_B_FUNCTION) begin
        b_func_nxt = cfg_wdata;
      end else if (cfg_addr == port_pkg::ADDR_C_PULLUP) begin
        c_pull_nxt = cfg_wdata & port_pkg::PORTC_MASK;
      end else if (cfg_addr == port_pkg::ADDR_C_OPTION) begin
        c_opt_nxt = cfg_wdata & port_pkg::PORTC_MASK;
      end else if (cfg_addr == port_pkg::ADDR_C_DIRECTION) begin
        c_dir_nxt      = cfg_wdata & port_pkg::PORTC_MASK;
        c_pull_act_nxt = c_pull_r;
        c_opt_act_nxt  = c_opt_r;
      end else if (cfg_addr == port_pkg::ADDR_C_FUNCTION) begin
        c_func_nxt = cfg_wdata & port_pkg::PORTC_MASK;
      end
    end
    // output register space is write-only
    if (out_wr) begin
      if (out_addr == port_pkg::ADDR_PORT_A) begin
        a_drv_nxt = out_wdata;
      end else if (out_addr == port_pkg::ADDR_PORT_B) begin
        b_drv_nxt = out_wdata;
      end else if (out_addr == port_pkg::ADDR_PORT_C) begin
        c_drv_nxt = out_wdata & port_pkg::PORTC_MASK;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      b_pull_r     <= port_pkg::RESET_CONFIG;
      b_opt_r      <= port_pkg::RESET_CONFIG;
      b_dir_r      <= port_pkg::RESET_CONFIG;
      b_func_r     <= port_pkg::RESET_CONFIG;
      c_pull_r     <= port_pkg::RESET_CONFIG;
      c_opt_r      <= port_pkg::RESET_CONFIG;
      c_dir_r      <= port_pkg::RESET_CONFIG;
      c_func_r     <= port_pkg::RESET_CONFIG;
      b_pull_act_r <= port_pkg::RESET_CONFIG;
      b_opt_act_r  <= port_pkg::RESET_CONFIG;
      c_pull_act_r <= port_pkg::RESET_CONFIG;
      c_opt_act_r  <= port_pkg::RESET_CONFIG;
      a_drv_r      <= port_pkg::RESET_DRIVE;
      b_drv_r      <= port_pkg::RESET_DRIVE;
      c_drv_r      <= port_pkg::RESET_DRIVE;
    end else begin
      b_pull_r     <= b_pull_nxt;
      b_opt_r      <= b_opt_nxt;
      b_dir_r      <= b_dir_nxt;
      b_func_r     <= b_func_nxt;
      c_pull_r     <= c_pull_nxt;
      c_opt_r      <= c_opt_nxt;
      c_dir_r      <= c_dir_nxt;
      c_func_r     <= c_func_nxt;
      b_pull_act_r <= b_pull_act_nxt;
      b_opt_act_r  <= b_opt_act_nxt;
      c_pull_act_r <= c_pull_act_nxt;
      c_opt_act_r  <= c_opt_act_nxt;
      a_drv_r      <= a_drv_nxt;
      b_drv_r      <= b_drv_nxt;
      c_drv_r      <= c_drv_nxt;
    end
  end

  // read path: input space mixes pins and drive by direction
  always_comb begin
    rdata_nxt  = 8'h00;
    rvalid_nxt = in_rd | cfg_rd;
    if (in_rd) begin
      // port a direction is outside this block; its pins read as levels
      if (in_addr == port_pkg::ADDR_PORT_A) begin
        rdata_nxt = a_sync_r;
      end else if (in_addr == port_pkg::ADDR_PORT_B) begin
        rdata_nxt = (b_sync_r & ~b_dir_r) | (b_drv_r & b_dir_r);
      end else if (in_addr == port_pkg::ADDR_PORT_C) begin
        rdata_nxt = ({2'b00, c_sync_r} & ~c_dir_r) | (c_drv_r & c_dir_r);
      end
    end else if (cfg_rd) begin
      if (cfg_addr == port_pkg::ADDR_B_PULLUP) begin
        rdata_nxt = b_pull_r;
      end else if (cfg_addr == port_pkg::ADDR_B_OPTION) begin
        rdata_nxt = b_opt_r;
      end else if (cfg_addr == port_pkg::ADDR_B_DIRECTION) begin
        rdata_nxt = b_dir_r;
      end else if (cfg_addr == port_pkg::ADDR_B_FUNCTION) begin
        rdata_nxt = b_func_r;
      end else if (cfg_addr == port_pkg::ADDR_C_PULLUP) begin
        rdata_nxt = c_pull_r;
      end else if (cfg_addr == port_pkg::ADDR_C_OPTION) begin
        rdata_nxt = c_opt_r;
      end else if (cfg_addr == port_pkg::ADDR_C_DIRECTION) begin
        rdata_nxt = c_dir_r;
      end else if (cfg_addr == port_pkg::ADDR_C_FUNCTION) begin
        rdata_nxt = c_func_r;
      end
    end
  end

  // registered read data, drive values and routing outputs
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdata_r              <= 8'h00;
      rvalid_r             <= 1'b0;
      porta_drive_bits_r   <= port_pkg::RESET_DRIVE;
      analog_channel_in_r  <= 8'h00;
      portc_function_bit_r <= 6'h00;
      timer_reset_in_r     <= 1'b0;
    end else begin
      rdata_r              <= rdata_nxt;
      rvalid_r             <= rvalid_nxt;
      porta_drive_bits_r   <= a_drv_r;
      analog_channel_in_r  <= b_func_r; // bit 0 also selects the reference
      portc_function_bit_r <= c_func_r[5:0];
      // timer reset input taken from pin level when routed
      timer_reset_in_r     <= c_func_r[port_pkg::PC_TIMER_RESET]
                              & c_sync_r[port_pkg::PC_TIMER_RESET];
    end
  end

  // port b pads; analog pins keep the digital driver off
  pin_cell_bank #(.WIDTH(8)) u_portb (
    .sys_clk      (sys_clk),
    .resetn       (resetn),
    .pull_bits    (b_pull_act_r),
    .option_bits  (b_opt_act_r),
    .dir_bits     (b_dir_r),
    .func_bits    (b_func_r),
    .drive_bits   (b_drv_r),
    .alt_out      (8'h00),
    .alt_oe       (8'h00),
    .pad_out_r    (portb_pad_out_r),
    .pad_oe_r     (portb_pad_oe_r),
    .pad_pullup_r (portb_pad_pullup_r),
    .pad_weak_r   (portb_pad_weak_r),
    .pad_irq_en_r (portb_pad_irq_en_r)
  );

  // port c pads; absent in small packages so data has no effect there
  pin_cell_bank #(.WIDTH(6)) u_portc (
    .sys_clk      (sys_clk),
    .resetn       (resetn),
    .pull_bits    (c_pull_act_r[5:0]),
    .option_bits  (c_opt_act_r[5:0]),
    .dir_bits     (c_dir_r[5:0]),
    .func_bits    (c_func_r[5:0]),
    .drive_bits   (c_drv_r[5:0]),
    .alt_out      (portc_alt_out),
    .alt_oe       (portc_alt_oe),
    .pad_out_r    (portc_pad_out_r),
    .pad_oe_r     (portc_pad_oe_r),
    .pad_pullup_r (portc_pad_pullup_r),
    .pad_weak_r   (portc_pad_weak_r),
    .pad_irq_en_r (portc_pad_irq_en_r)
  );

  // assertions
  sequence s_dir_write_b;
    cfg_wr && cfg_addr == port_pkg::ADDR_B_DIRECTION;
  endsequence

  a_cfg_readback: assert property (@(posedge sys_clk) disable iff (!resetn)
    cfg_wr && cfg_addr == port_pkg::ADDR_B_OPTION ##1 !cfg_wr ##1 cfg_rd && !in_rd
      && cfg_addr == port_pkg::ADDR_B_OPTION |=> rdata_r == $past(cfg_wdata, 3))
    else $error("option register readback mismatch");
  a_pull_latch_dir: assert property (@(posedge sys_clk) disable iff (!resetn)
    !(cfg_wr && cfg_addr == port_pkg::ADDR_B_DIRECTION)
      |=> b_pull_act_r == $past(b_pull_act_r))
    else $error("pull-up took effect without direction write");
  a_pull_applied: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_dir_write_b |=> b_pull_act_r == $past(b_pull_r))
    else $error("pull-up not latched on direction write");
  a_portc_upper: assert property (@(posedge sys_clk) disable iff (!resetn)
    (c_pull_r[7:6] | c_opt_r[7:6] | c_dir_r[7:6] | c_func_r[7:6]) == 2'b00)
    else $error("port c upper bits not zero");
  a_drive_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    out_wr && out_addr == port_pkg::ADDR_PORT_A |=> ##1 porta_drive_bits_r == $past(out_wdata, 2))
    else $error("port a drive not applied");
  a_read_output: assert property (@(posedge sys_clk) disable iff (!resetn)
    in_rd && in_addr == port_pkg::ADDR_PORT_B
      |=> ((rdata_r ^ $past(b_drv_r)) & $past(b_dir_r)) == 8'h00)
    else $error("output pin read did not return drive value");
  a_read_input: assert property (@(posedge sys_clk) disable iff (!resetn)
    in_rd && in_addr == port_pkg::ADDR_PORT_B
      |=> ((rdata_r ^ $past(b_sync_r)) & ~$past(b_dir_r)) == 8'h00)
    else $error("input pin read did not return level");
  a_rvalid_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
    (in_rd || cfg_rd) |=> rvalid_r)
    else $error("read not answered");
  a_drive_reset: assert property (@(posedge sys_clk)
    !resetn |=> porta_drive_bits_r == 8'h00 && b_drv_r == 8'h00)
    else $error("drive registers not cleared by reset");
endmodule

// *** verilog/port_pkg.sv ***
// Purpose: shared constants of the port configuration and data register block
// Assumes: byte-wide register space reached by the core's register instructions
// Notes:   three address spaces: input (read), output (write), configuration (rw)
package port_pkg;
  // input and output register space addresses
  localparam logic [7:0] ADDR_PORT_A       = 8'h00;
  localparam logic [7:0] ADDR_PORT_B       = 8'h01;
  localparam logic [7:0] ADDR_PORT_C       = 8'h02;
  // configuration register space addresses
  localparam logic [7:0] ADDR_B_PULLUP     = 8'h1c;
  localparam logic [7:0] ADDR_B_OPTION     = 8'h1d;
  localparam logic [7:0] ADDR_B_DIRECTION  = 8'h1e;
  localparam logic [7:0] ADDR_B_FUNCTION   = 8'h1f;
  localparam logic [7:0] ADDR_C_PULLUP     = 8'h20;
  localparam logic [7:0] ADDR_C_OPTION     = 8'h21;
  localparam logic [7:0] ADDR_C_DIRECTION  = 8'h22;
  localparam logic [7:0] ADDR_C_FUNCTION   = 8'h23;
  // reset values
  localparam logic [7:0] RESET_CONFIG      = 8'h00;
  localparam logic [7:0] RESET_DRIVE       = 8'h00;
  // port c has six implemented bits
  localparam logic [7:0] PORTC_MASK        = 8'h3f;
  // port c alternate function bit positions
  localparam int         PC_TIMER_RESET    = 5;
  localparam int         PC_SERIAL_TX      = 4;
  localparam int         PC_SPI_SS         = 3;
  localparam int         PC_SPI_MISO       = 2;
  localparam int         PC_SPI_MOSI       = 1;
  localparam int         PC_SPI_SCK        = 0;
endpackage

// *** verilog/pin_cell_bank.sv ***
// Purpose: per-pin mode decode and pad control for one port
// Assumes: mode bits come from latched configuration registers
// Notes:   output enable high while the pad is actively driven
module pin_cell_bank #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  // latched configuration
  input  wire logic [WIDTH-1:0] pull_bits,
  input  wire logic [WIDTH-1:0] option_bits,
  input  wire logic [WIDTH-1:0] dir_bits,
  input  wire logic [WIDTH-1:0] func_bits,
  input  wire logic [WIDTH-1:0] drive_bits,
  // alternate function output data and enable
  input  wire logic [WIDTH-1:0] alt_out,
  input  wire logic [WIDTH-1:0] alt_oe,
  // pad controls
  output logic      [WIDTH-1:0] pad_out_r,
  output logic      [WIDTH-1:0] pad_oe_r,
  output logic      [WIDTH-1:0] pad_pullup_r,
  output logic      [WIDTH-1:0] pad_weak_r,
  output logic      [WIDTH-1:0] pad_irq_en_r
);
  logic [WIDTH-1:0] out_nxt;
  logic [WIDTH-1:0] oe_nxt;
  logic [WIDTH-1:0] pu_nxt;
  logic [WIDTH-1:0] weak_nxt;
  logic [WIDTH-1:0] irq_nxt;

  // one mode decoder per pin from pull-up, option, direction
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    always_comb begin
      out_nxt[i]  = drive_bits[i];
      oe_nxt[i]   = 1'b0;
      pu_nxt[i]   = pull_bits[i];
      weak_nxt[i] = 1'b0;
      irq_nxt[i]  = 1'b0;
      case ({pull_bits[i], option_bits[i], dir_bits[i]})
        3'b010, 3'b110: irq_nxt[i] = 1'b1;
        3'b001, 3'b101: oe_nxt[i] = 1'b1;
        3'b011: begin
          oe_nxt[i] = ~drive_bits[i]; // open drain only pulls low
          out_nxt[i] = 1'b0;
        end
        3'b111: begin
          weak_nxt[i] = 1'b1;
          pu_nxt[i]   = 1'b1;
          oe_nxt[i]   = ~drive_bits[i];
          out_nxt[i]  = 1'b0;
        end
        default: ;
      endcase
      // peripheral takes the pad data when the function bit is set
      if (func_bits[i]) begin
        out_nxt[i] = alt_out[i];
        oe_nxt[i]  = alt_oe[i] & dir_bits[i];
        irq_nxt[i] = 1'b0;
      end
    end
  end

  // register pad controls so outputs come from flip-flops
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pad_out_r    <= '0;
      pad_oe_r     <= '0;
      pad_pullup_r <= '0;
      pad_weak_r   <= '0;
      pad_irq_en_r <= '0;
    end else begin
      pad_out_r    <= out_nxt;
      pad_oe_r     <= oe_nxt;
      pad_pullup_r <= pu_nxt;
      pad_weak_r   <= weak_nxt;
      pad_irq_en_r <= irq_nxt;
    end
  end
endmodule

// *** testbench/pin_model.sv ***
// Purpose: pads and board wiring seen by one port of the block
// Assumes: pad controls registered on sys_clk, outside drive set by the bench
// Notes:   an undriven pin without pull-up floats and shows a toggling level
module pin_model #(
  parameter int W = 8
) (
  // clock
  input  wire logic         sys_clk,
  // pad controls from the block
  input  wire logic [W-1:0] pad_out,
  input  wire logic [W-1:0] pad_oe,
  input  wire logic [W-1:0] pad_pull,
  input  wire logic [W-1:0] pad_weak,
  // outside drive
  input  wire logic [W-1:0] ext,
  input  wire logic [W-1:0] ext_en,
  // resolved pin level
  output logic      [W-1:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tgl_r = 1'b0;

  // a floating pin must not settle to a convenient value
  always_ff @(posedge sys_clk) begin
    tgl_r <= ~tgl_r;
  end

  // pad drive wins, then outside drive, then pull-up, else float
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (pad_oe[i]) level[i] = pad_out[i];
      else if (ext_en[i]) level[i] = ext[i];
      else if (pad_pull[i] | pad_weak[i]) level[i] = 1'b1;
      else level[i] = tgl_r ^ i[0];
    end
  end
endmodule

// *** testbench/tb.sv ***
// Purpose: register-level test of port configuration and data registers
// Assumes: strobes driven on falling edges, read data one cycle after the read
// Notes:   pads settle two cycles after a write, so checks wait four cycles
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk, resetn, in_rd, out_wr, cfg_rd, cfg_wr, rvalid_r, timer_reset_in_r;
  logic [7:0] in_addr, out_addr, out_wdata, cfg_addr, cfg_wdata, rdata_r, porta_pin_in;
  logic [7:0] portb_pin_in, porta_drive_bits_r, b_out, b_oe, b_pull, b_weak, b_irq, b_ana;
  logic [7:0] b_ext, b_en, exp8;
  logic [5:0] portc_pin_in, c_out, c_oe, c_pull, c_weak, c_irq, c_fn, alt_out, alt_oe;
  logic [5:0] c_ext, c_en;
  int         num_errors, cmp_count;

  port_config_and_data_regs port_config_and_data_regs_i (
    .sys_clk(sys_clk), .resetn(resetn), .in_rd(in_rd), .in_addr(in_addr),
    .out_wr(out_wr), .out_addr(out_addr), .out_wdata(out_wdata), .cfg_rd(cfg_rd),
    .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .rdata_r(rdata_r),
    .rvalid_r(rvalid_r), .porta_pin_in(porta_pin_in), .portb_pin_in(portb_pin_in),
    .portc_pin_in(portc_pin_in), .porta_drive_bits_r(porta_drive_bits_r),
    .portb_pad_out_r(b_out), .portb_pad_oe_r(b_oe), .portb_pad_pullup_r(b_pull),
    .portb_pad_weak_r(b_weak), .portb_pad_irq_en_r(b_irq), .analog_channel_in_r(b_ana),
    .portc_pad_out_r(c_out), .portc_pad_oe_r(c_oe), .portc_pad_pullup_r(c_pull),
    .portc_pad_weak_r(c_weak), .portc_pad_irq_en_r(c_irq), .portc_alt_out(alt_out),
    .portc_alt_oe(alt_oe), .portc_function_bit_r(c_fn), .timer_reset_in_r(timer_reset_in_r));
  pin_model #(.W(8)) pin_model_i (.sys_clk(sys_clk), .pad_out(b_out), .pad_oe(b_oe),
    .pad_pull(b_pull), .pad_weak(b_weak), .ext(b_ext), .ext_en(b_en), .level(portb_pin_in));
  pin_model #(.W(6)) pin_model_c_i (.sys_clk(sys_clk), .pad_out(c_out), .pad_oe(c_oe),
    .pad_pull(c_pull), .pad_weak(c_weak), .ext(c_ext), .ext_en(c_en), .level(portc_pin_in));

  // clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    cfg_wr = 1'b1; cfg_addr = a; cfg_wdata = d;
    @(negedge sys_clk);
    cfg_wr = 1'b0;
  endtask

  task automatic out_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    out_wr = 1'b1; out_addr = a; out_wdata = d;
    @(negedge sys_clk);
    out_wr = 1'b0;
  endtask

  // read data stands only in the cycle after the read edge
  task automatic do_read(input logic cfg, input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    if (cfg) begin cfg_rd = 1'b1; cfg_addr = a; end
    else begin in_rd = 1'b1; in_addr = a; end
    @(negedge sys_clk);
    cfg_rd = 1'b0;
    in_rd = 1'b0;
    chk("rvalid", {7'h00, rvalid_r}, 8'h01);
    chk("rdata", rdata_r, exp);
  endtask

  task automatic stop_test();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end

  initial begin
    {in_rd, out_wr, cfg_rd, cfg_wr, in_addr, out_addr, out_wdata} = '0;
    {cfg_addr, cfg_wdata, porta_pin_in, b_ext, b_en, c_ext, c_en, alt_out, alt_oe} = '0;
    num_errors = 0;
    cmp_count = 0;
    resetn = 1'b0;
    idle(16);
    resetn = 1'b1;
    chk("drive a", porta_drive_bits_r, 8'h00);
    chk("pad out b", b_out, 8'h00);
    for (logic [7:0] a = 8'h1c; a <= 8'h23; a++) do_read(1'b1, a, 8'h00);
    // pull-up alone must not reach the pads before a direction write
    cfg_write(8'h1c, 8'hff);
    cfg_write(8'h20, 8'hff);
    idle(4);
    chk("pullup b", b_pull, 8'h00);
    chk("pullup c", {2'b00, c_pull}, 8'h00);
    // read back every configuration register, port c keeps six bits
    for (logic [7:0] a = 8'h1c; a <= 8'h23; a++) begin
      cfg_write(a, a ^ 8'h96);
      exp8 = (a >= 8'h20) ? ((a ^ 8'h96) & 8'h3f) : (a ^ 8'h96);
      do_read(1'b1, a, exp8);
    end
    cfg_write(8'h1f, 8'h00);
    cfg_write(8'h23, 8'h00);
    do_read(1'b1, 8'h30, 8'h00);
    do_read(1'b0, 8'h03, 8'h00);
    // output registers, port a pins read back not the written value
    porta_pin_in = 8'h3c;
    out_write(8'h00, 8'h5a);
    out_write(8'h01, 8'ha5);
    out_write(8'h02, 8'hea);
    idle(4);
    chk("drive a", porta_drive_bits_r, 8'h5a);
    do_read(1'b0, 8'h00, 8'h3c);
    // every mode, direction written last
    for (int m = 0; m < 8; m++) begin
      cfg_write(8'h1c, m[2] ? 8'hff : 8'h00);
      cfg_write(8'h1d, m[1] ? 8'hff : 8'h00);
      cfg_write(8'h20, m[2] ? 8'h3f : 8'h00);
      cfg_write(8'h21, m[1] ? 8'h3f : 8'h00);
      cfg_write(8'h1e, m[0] ? 8'hff : 8'h00);
      cfg_write(8'h22, m[0] ? 8'h3f : 8'h00);
      idle(4);
      exp8 = m[0] ? (m[1] ? 8'h5a : 8'hff) : 8'h00;
      chk("oe b", b_oe, exp8);
      chk("oe c", {2'b00, c_oe}, m[0] ? (m[1] ? 8'h15 : 8'h3f) : 8'h00);
      exp8 = m[0] ? (m[1] ? 8'h00 : 8'ha5) : 8'h00;
      if (m[0]) chk("out b", b_out, exp8);
      if (!(m[0] && m[1])) chk("pullup b", b_pull, m[2] ? 8'hff : 8'h00);
      if (!(m[0] && m[1])) chk("pullup c", {2'b00, c_pull}, m[2] ? 8'h3f : 8'h00);
      chk("weak b", b_weak, (m == 7) ? 8'hff : 8'h00);
      chk("irq b", b_irq, (!m[0] && m[1]) ? 8'hff : 8'h00);
      chk("weak c", {2'b00, c_weak}, (m == 7) ? 8'h3f : 8'h00);
      chk("irq c", {2'b00, c_irq}, (!m[0] && m[1]) ? 8'h3f : 8'h00);
    end
    // mixed direction: outputs read the buffer, inputs read the pins
    cfg_write(8'h1c, 8'h00);
    cfg_write(8'h1d, 8'h00);
    cfg_write(8'h1e, 8'h0f);
    cfg_write(8'h20, 8'h00);
    cfg_write(8'h21, 8'h00);
    cfg_write(8'h22, 8'h07);
    b_ext = 8'h3c;
    b_en = 8'hff;
    c_ext = 6'h38;
    c_en = 6'h3f;
    idle(4);
    do_read(1'b0, 8'h01, 8'h35);
    do_read(1'b0, 8'h02, 8'h3a);
    // port c peripheral routing
    alt_out = 6'h3f;
    alt_oe = 6'h15;
    cfg_write(8'h23, 8'h3f);
    cfg_write(8'h22, 8'h3f);
    idle(4);
    chk("func c", {2'b00, c_fn}, 8'h3f);
    chk("timer reset", {7'h00, timer_reset_in_r}, 8'h01);
    chk("oe c alt", {2'b00, c_oe}, 8'h15);
    chk("out c alt", {2'b00, c_out & alt_oe}, 8'h15);
    cfg_write(8'h23, 8'h1f);
    idle(4);
    chk("timer reset", {7'h00, timer_reset_in_r}, 8'h00);
    cfg_write(8'h1f, 8'h81);
    idle(4);
    chk("analog b", b_ana, 8'h81);
    do_read(1'b1, 8'h1f, 8'h81);
    // park port b as input with pull-up, option and direction zero
    b_en = 8'h00;
    cfg_write(8'h1c, 8'hff);
    cfg_write(8'h1d, 8'h00);
    cfg_write(8'h1e, 8'h00);
    idle(4);
    chk("pullup b", b_pull, 8'hff);
    chk("oe b", b_oe, 8'h00);
    stop_test();
  end
endmodule
